// ===== src/acrd_pkg.sv
// constants and types for the array clock and set/reset distribution block
package acrd_pkg;
   // ************************************************************
   // array geometry
   // ************************************************************
   localparam int ACRD_NUM_GCB = 8;
   localparam int ACRD_NUM_FAST = 4;
   localparam int ACRD_NUM_CORNER = 4;
   localparam int ACRD_NUM_COL = 4;
   localparam int ACRD_SEC_PER_COL = 2;
   localparam int ACRD_NUM_SEC = ACRD_NUM_COL * ACRD_SEC_PER_COL;
   localparam int ACRD_CELLS_PER_SEC = 4;
   localparam int ACRD_NUM_CELL = ACRD_NUM_SEC * ACRD_CELLS_PER_SEC;
   localparam int ACRD_NUM_UIO = 8;

   // ************************************************************
   // synchronised pin bundle layout
   // ************************************************************
   localparam int ACRD_PIN_GCB_LSB = 0;
   localparam int ACRD_PIN_FAST_LSB = 8;
   localparam int ACRD_PIN_CORNER_LSB = 12;
   localparam int ACRD_PIN_P4_LSB = 16;
   localparam int ACRD_PIN_P5_LSB = 24;
   localparam int ACRD_PIN_UIO_LSB = 32;
   localparam int ACRD_PIN_D_LSB = 40;
   localparam int ACRD_PIN_W = 72;

   // ************************************************************
   // register byte offsets (apb, 32-bit words)
   // ************************************************************
   localparam logic [11:0] ACRD_OFS_CTRL = 12'h000;
   localparam logic [11:0] ACRD_OFS_STATUS = 12'h004;
   localparam logic [11:0] ACRD_OFS_COL_BASE = 12'h010;
   localparam logic [11:0] ACRD_OFS_SEC_BASE = 12'h040;
   localparam logic [11:0] ACRD_OFS_CELL_BASE = 12'h100;
   localparam logic [11:0] ACRD_OFS_CELL_Q = 12'h200;
   localparam logic [11:0] ACRD_OFS_SEC_LVL = 12'h204;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int ACRD_CTRL_DONE_BIT = 0;
   localparam int ACRD_CTRL_INJ_LSB = 8;
   localparam int ACRD_CTRL_GSR_LSB = 16;
   localparam int ACRD_SEC_CLK_SRC_BIT = 0;
   localparam int ACRD_SEC_CLK_MODE_LSB = 1;
   localparam int ACRD_SEC_SR_SRC_BIT = 3;
   localparam int ACRD_SEC_SR_INV_BIT = 4;
   localparam int ACRD_CELL_SETS_BIT = 0;
   localparam int ACRD_CELL_ACT_HIGH_BIT = 1;
   localparam int ACRD_CELL_FALL_BIT = 2;
   localparam int ACRD_CELL_INIT_SET_BIT = 3;

   // column selector codes above the global buses
   localparam logic [3:0] ACRD_COL_SEL_FAST_A = 4'h8;
   localparam logic [3:0] ACRD_COL_SEL_FAST_B = 4'h9;

   // ************************************************************
   // values after reset
   // ************************************************************
   localparam logic [3:0] ACRD_RST_COL = 4'h0;
   localparam logic [4:0] ACRD_RST_SEC = 5'h00;
   localparam logic [3:0] ACRD_RST_CELL = 4'h0;

   typedef enum logic [1:0] {
      ACRD_CLK_PASS = 2'b00,
      ACRD_CLK_INV = 2'b01,
      ACRD_CLK_TIE0 = 2'b11
   } acrd_clk_mode_t;
endpackage : acrd_pkg

// ===== src/acrd_top.sv
// array clock and set/reset distribution with apb configuration
// limitations: pin clocks are sampled by the system clock, so they must
// stay below half its rate; set/reset reaches the cells at the fourth system
// clock edge after the pin changes, which stands in for the asynchronous action of the real cell
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module acrd_top (
   // clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // clock pins
   input wire logic [acrd_pkg::ACRD_NUM_GCB-1:0] GLOBAL_CLOCK_BUS,
   input wire logic FAST_CLOCK_LEFT_A,
   input wire logic FAST_CLOCK_LEFT_B,
   input wire logic FAST_CLOCK_RIGHT_A,
   input wire logic FAST_CLOCK_RIGHT_B,
   input wire logic [acrd_pkg::ACRD_NUM_CORNER-1:0] CORNER_DERIVED_CLOCK,
   // express buses and user io
   input wire logic [acrd_pkg::ACRD_NUM_SEC-1:0] PLANE4_EXPRESS,
   input wire logic [acrd_pkg::ACRD_NUM_SEC-1:0] PLANE5_EXPRESS,
   input wire logic [acrd_pkg::ACRD_NUM_UIO-1:0] USER_IO,
   // cell registers
   input wire logic [acrd_pkg::ACRD_NUM_CELL-1:0] CELL_D,
   output logic [acrd_pkg::ACRD_NUM_CELL-1:0] CELL_Q,
   // delivered sector signals
   output logic [acrd_pkg::ACRD_NUM_SEC-1:0] SECTOR_CLK,
   output logic [acrd_pkg::ACRD_NUM_SEC-1:0] SECTOR_SR,
   output logic CONFIG_DONE
);
   import acrd_pkg::*;

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic [ACRD_PIN_W-1:0] meta_q;
      logic [ACRD_PIN_W-1:0] pin_q;
      logic done_q;
      logic live_q;
      logic [ACRD_NUM_GCB-1:0] inject_q;
      logic [2:0] gsr_sel_q;
      logic [ACRD_NUM_COL-1:0][3:0] col_q;
      logic [ACRD_NUM_SEC-1:0][4:0] sec_q;
      logic [ACRD_NUM_CELL-1:0][3:0] cell_cfg_q;
      logic [ACRD_NUM_SEC-1:0] sclk_q;
      logic [ACRD_NUM_SEC-1:0] sclk_prev_q;
      logic [ACRD_NUM_SEC-1:0] ssr_q;
      logic [ACRD_NUM_CELL-1:0] cell_q;
      logic pready_q;
      logic pslverr_q;
      logic [31:0] prdata_q;
   } acrd_state_t;

   acrd_state_t s_q;
   acrd_state_t s_d;

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      logic [ACRD_NUM_GCB-1:0] gbus;
      logic [ACRD_NUM_FAST-1:0] fast;
      logic [ACRD_NUM_CORNER-1:0] corner;
      logic [ACRD_NUM_SEC-1:0] p4;
      logic [ACRD_NUM_SEC-1:0] p5;
      logic [ACRD_NUM_UIO-1:0] uio;
      logic [ACRD_NUM_CELL-1:0] din;
      logic [ACRD_NUM_COL-1:0] colclk;
      logic gsr;
      logic src;
      logic chosen;
      logic lvl;
      logic act;
      logic edge_seen;
      logic [3:0] sel;
      logic [4:0] sc;
      logic [3:0] cc;
      logic [31:0] rd;
      logic hit;
      logic wr;
      int c;
      int s;
      gbus = '0;
      fast = '0;
      corner = '0;
      p4 = '0;
      p5 = '0;
      uio = '0;
      din = '0;
      colclk = '0;
      gsr = 1'b0;
      src = 1'b0;
      chosen = 1'b0;
      lvl = 1'b0;
      act = 1'b0;
      edge_seen = 1'b0;
      sel = '0;
      sc = '0;
      cc = '0;
      rd = '0;
      hit = 1'b0;
      wr = 1'b0;
      c = 0;
      s = 0;
      s_d = s_q;

      // two-stage synchroniser for every pin input
      s_d.meta_q = {
         CELL_D,
         USER_IO,
         PLANE5_EXPRESS,
         PLANE4_EXPRESS,
         CORNER_DERIVED_CLOCK,
         FAST_CLOCK_RIGHT_B,
         FAST_CLOCK_RIGHT_A,
         FAST_CLOCK_LEFT_B,
         FAST_CLOCK_LEFT_A,
         GLOBAL_CLOCK_BUS
      };
      s_d.pin_q = s_q.meta_q;

      gbus = s_q.pin_q[ACRD_PIN_GCB_LSB +: ACRD_NUM_GCB];
      fast = s_q.pin_q[ACRD_PIN_FAST_LSB +: ACRD_NUM_FAST];
      corner = s_q.pin_q[ACRD_PIN_CORNER_LSB +: ACRD_NUM_CORNER];
      p4 = s_q.pin_q[ACRD_PIN_P4_LSB +: ACRD_NUM_SEC];
      p5 = s_q.pin_q[ACRD_PIN_P5_LSB +: ACRD_NUM_SEC];
      uio = s_q.pin_q[ACRD_PIN_UIO_LSB +: ACRD_NUM_UIO];
      din = s_q.pin_q[ACRD_PIN_D_LSB +: ACRD_NUM_CELL];

      // ************************************************************
      // global buses and column selectors
      // ************************************************************
      // each bus follows its own pin unless its corner access point is enabled
      for (int i = 0; i < ACRD_NUM_GCB; i++) begin
         if (s_q.inject_q[i]) begin
            gbus[i] = corner[i % ACRD_NUM_CORNER];
         end
      end

      for (int i = 0; i < ACRD_NUM_COL; i++) begin
         sel = s_q.col_q[i];
         if (sel[3] == 1'b0) begin
            colclk[i] = gbus[sel[2:0]];
         end else if (i == 0 && sel == ACRD_COL_SEL_FAST_A) begin
            colclk[i] = fast[0];
         end else if (i == 0 && sel == ACRD_COL_SEL_FAST_B) begin
            colclk[i] = fast[1];
         end else if (i == ACRD_NUM_COL - 1 && sel == ACRD_COL_SEL_FAST_A) begin
            colclk[i] = fast[2];
         end else if (i == ACRD_NUM_COL - 1 && sel == ACRD_COL_SEL_FAST_B) begin
            colclk[i] = fast[3];
         end else begin
            // codes the column cannot use give a quiet clock, not a stray bus
            colclk[i] = 1'b0;
         end
      end

      // single global set/reset net, shared by all columns
      // fed from user io only, never from the clock pins
      gsr = uio[s_q.gsr_sel_q];

      // ************************************************************
      // sector selectors
      // ************************************************************
      for (int i = 0; i < ACRD_NUM_SEC; i++) begin
         c = i / ACRD_SEC_PER_COL;
         sc = s_q.sec_q[i];
         src = sc[ACRD_SEC_CLK_SRC_BIT] ? p4[i] : colclk[c];
         case (acrd_clk_mode_t'(sc[ACRD_SEC_CLK_MODE_LSB +: 2]))
            ACRD_CLK_PASS: begin
               lvl = src;
            end
            ACRD_CLK_INV: begin
               lvl = ~src;
            end
            ACRD_CLK_TIE0: begin
               lvl = 1'b0;
            end
            default: begin
               lvl = 1'b0;
            end
         endcase

         chosen = sc[ACRD_SEC_SR_SRC_BIT] ? gsr : p5[i];
         // every sector switches on the one done bit in the same cycle
         if (s_q.done_q) begin
            s_d.sclk_q[i] = lvl;
            s_d.ssr_q[i] = chosen ^ sc[ACRD_SEC_SR_INV_BIT];
         end else begin
            s_d.sclk_q[i] = 1'b0;
            s_d.ssr_q[i] = 1'b1;
         end
      end
      s_d.sclk_prev_q = s_q.sclk_q;
      // sector set/reset carries its configured source one cycle after done
      s_d.live_q = s_q.done_q;

      // ************************************************************
      // cell registers
      // ************************************************************
      for (int k = 0; k < ACRD_NUM_CELL; k++) begin
         s = k / ACRD_CELLS_PER_SEC;
         cc = s_q.cell_cfg_q[k];
         act = cc[ACRD_CELL_ACT_HIGH_BIT] ? s_q.ssr_q[s] : ~s_q.ssr_q[s];
         // the first done cycle still shows the forced sector level, which would
         // wrongly act on active-high cells and overwrite the initial state
         if (!s_q.live_q) begin
            act = 1'b0;
         end
         // edges are found against the level delivered one cycle earlier
         if (cc[ACRD_CELL_FALL_BIT]) begin
            edge_seen = ~s_q.sclk_q[s] & s_q.sclk_prev_q[s];
         end else begin
            edge_seen = s_q.sclk_q[s] & ~s_q.sclk_prev_q[s];
         end
         if (!s_q.done_q) begin
            s_d.cell_q[k] = 1'b1;
         end else if (act) begin
            // set/reset overrides the clock, no edge needed
            s_d.cell_q[k] = cc[ACRD_CELL_SETS_BIT];
         end else if (edge_seen) begin
            s_d.cell_q[k] = din[k];
         end
      end

      // ************************************************************
      // apb read decode
      // ************************************************************
      if (PADDR == ACRD_OFS_CTRL) begin
         hit = 1'b1;
         rd[ACRD_CTRL_DONE_BIT] = s_q.done_q;
         rd[ACRD_CTRL_INJ_LSB +: ACRD_NUM_GCB] = s_q.inject_q;
         rd[ACRD_CTRL_GSR_LSB +: 3] = s_q.gsr_sel_q;
      end

      if (PADDR == ACRD_OFS_STATUS) begin
         hit = 1'b1;
         rd[ACRD_NUM_GCB-1:0] = gbus;
         rd[ACRD_NUM_GCB +: ACRD_NUM_COL] = colclk;
         rd[16] = gsr;
      end

      if (PADDR == ACRD_OFS_CELL_Q) begin
         hit = 1'b1;
         rd = s_q.cell_q;
      end

      if (PADDR == ACRD_OFS_SEC_LVL) begin
         hit = 1'b1;
         rd[ACRD_NUM_SEC-1:0] = s_q.sclk_q;
         rd[16 +: ACRD_NUM_SEC] = s_q.ssr_q;
      end

      for (int i = 0; i < ACRD_NUM_COL; i++) begin
         if (PADDR == ACRD_OFS_COL_BASE + 12'(4 * i)) begin
            hit = 1'b1;
            rd[3:0] = s_q.col_q[i];
         end
      end

      for (int i = 0; i < ACRD_NUM_SEC; i++) begin
         if (PADDR == ACRD_OFS_SEC_BASE + 12'(4 * i)) begin
            hit = 1'b1;
            rd[4:0] = s_q.sec_q[i];
         end
      end

      for (int i = 0; i < ACRD_NUM_CELL; i++) begin
         if (PADDR == ACRD_OFS_CELL_BASE + 12'(4 * i)) begin
            hit = 1'b1;
            rd[3:0] = s_q.cell_cfg_q[i];
         end
      end

      // zero wait states: answer is set up during the setup cycle
      s_d.pready_q = PSEL & ~PENABLE;
      if (PSEL && !PENABLE) begin
         s_d.prdata_q = PWRITE ? 32'h0000_0000 : rd;
         s_d.pslverr_q = ~hit;
      end else begin
         s_d.prdata_q = 32'h0000_0000;
         s_d.pslverr_q = 1'b0;
      end

      // ************************************************************
      // apb write
      // ************************************************************
      // a write lands only in the access cycle that this slave has made ready
      wr = PSEL & PENABLE & PWRITE & s_q.pready_q & hit;
      if (wr && PADDR == ACRD_OFS_CTRL) begin
         s_d.done_q = PWDATA[ACRD_CTRL_DONE_BIT];
         s_d.inject_q = PWDATA[ACRD_CTRL_INJ_LSB +: ACRD_NUM_GCB];
         s_d.gsr_sel_q = PWDATA[ACRD_CTRL_GSR_LSB +: 3];
         // completing configuration loads every register's initial state
         if (PWDATA[ACRD_CTRL_DONE_BIT] && !s_q.done_q) begin
            for (int k = 0; k < ACRD_NUM_CELL; k++) begin
               s_d.cell_q[k] = s_q.cell_cfg_q[k][ACRD_CELL_INIT_SET_BIT];
            end
         end
      end

      for (int i = 0; i < ACRD_NUM_COL; i++) begin
         if (wr && PADDR == ACRD_OFS_COL_BASE + 12'(4 * i)) begin
            s_d.col_q[i] = PWDATA[3:0];
         end
      end

      for (int i = 0; i < ACRD_NUM_SEC; i++) begin
         if (wr && PADDR == ACRD_OFS_SEC_BASE + 12'(4 * i)) begin
            s_d.sec_q[i] = PWDATA[4:0];
         end
      end

      for (int i = 0; i < ACRD_NUM_CELL; i++) begin
         if (wr && PADDR == ACRD_OFS_CELL_BASE + 12'(4 * i)) begin
            s_d.cell_cfg_q[i] = PWDATA[3:0];
         end
      end
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         s_q <= '0;
         s_q.col_q <= {ACRD_NUM_COL{ACRD_RST_COL}};
         s_q.sec_q <= {ACRD_NUM_SEC{ACRD_RST_SEC}};
         s_q.cell_cfg_q <= {ACRD_NUM_CELL{ACRD_RST_CELL}};
         s_q.ssr_q <= '1;
         s_q.cell_q <= '1;
      end else begin
         s_q <= s_d;
      end
   end

   assign PRDATA = s_q.prdata_q;
   assign PREADY = s_q.pready_q;
   assign PSLVERR = s_q.pslverr_q;
   assign CELL_Q = s_q.cell_q;
   assign SECTOR_CLK = s_q.sclk_q;
   assign SECTOR_SR = s_q.ssr_q;
   assign CONFIG_DONE = s_q.done_q;
endmodule : acrd_top
`default_nettype wire

// ===== tb/acrd_cell_user.sv
// behavioural user logic that feeds every cell register its next value
`timescale 1ns/1ps
`default_nettype none
module acrd_cell_user (
   // cell side
   input wire logic [acrd_pkg::ACRD_NUM_CELL-1:0] cell_q,
   input wire logic [acrd_pkg::ACRD_NUM_CELL-1:0] flip_mask,
   output logic [acrd_pkg::ACRD_NUM_CELL-1:0] cell_d
);
   import acrd_pkg::*;
   // flipping chosen bits makes each capture by a chosen cell visible, even of a cell at its old value
   assign cell_d = cell_q ^ flip_mask;
endmodule : acrd_cell_user
`default_nettype wire

// ===== tb/acrd_chk_asserts.sv
// port assertions for the clock and set/reset distribution block
`timescale 1ns/1ps
`default_nettype none
module acrd_chk (
   // clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // apb
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic [31:0] PRDATA,
   // distribution
   input wire logic [acrd_pkg::ACRD_NUM_CELL-1:0] CELL_Q,
   input wire logic [acrd_pkg::ACRD_NUM_SEC-1:0] SECTOR_CLK,
   input wire logic [acrd_pkg::ACRD_NUM_SEC-1:0] SECTOR_SR,
   input wire logic CONFIG_DONE
);
   import acrd_pkg::*;
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_B);
   // ********
   // pre-configuration
   // ********
   // one cycle of slack: sector outputs are registered behind the done bit
   property p_pre_clk; !CONFIG_DONE && !$past(CONFIG_DONE) |-> SECTOR_CLK == '0; endproperty
   a_pre_clk: assert property (p_pre_clk) else $error("sector clock live early");
   property p_pre_q; !CONFIG_DONE && !$past(CONFIG_DONE) |-> &CELL_Q; endproperty
   a_pre_q: assert property (p_pre_q) else $error("cell not held high");
   property p_pre_sr; $fell(CONFIG_DONE) |=> &SECTOR_SR && SECTOR_CLK == '0; endproperty
   a_pre_sr: assert property (p_pre_sr) else $error("sectors not reverted together");
   // ********
   // cell registers
   // ********
   // writes are excluded because a cell polarity change may act with no port change
   for (genvar s = 0; s < ACRD_NUM_SEC; s++) begin : g_sec
      property p_cell_hold;
         // set/reset starts to act one cycle after the sector outputs go live
         CONFIG_DONE && $past(CONFIG_DONE, 3) && !$past(PSEL) && !$past(PSEL, 2)
         && $past(SECTOR_CLK[s]) == $past(SECTOR_CLK[s], 2)
         && $past(SECTOR_SR[s]) == $past(SECTOR_SR[s], 2) |-> $stable(CELL_Q[4*s+:4]);
      endproperty
      a_cell_hold: assert property (p_cell_hold) else $error("cell changed without cause");
   end
   // ********
   // apb answer
   // ********
   property p_rdy; PSEL && !PENABLE |=> PREADY; endproperty
   a_rdy: assert property (p_rdy) else $error("no ready after setup");
   property p_rdy_pulse; $rose(PREADY) |=> !PREADY; endproperty
   a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready longer than one cycle");
   property p_err; PSLVERR |-> PREADY && PSEL && PENABLE; endproperty
   a_err: assert property (p_err) else $error("error outside access");
   property p_rd_zero; !PREADY |-> PRDATA == '0; endproperty
   a_rd_zero: assert property (p_rd_zero) else $error("read data outside access");
   cover property ($rose(CONFIG_DONE));
   cover property ($fell(CONFIG_DONE));
   cover property (PSLVERR);
endmodule : acrd_chk
bind acrd_top acrd_chk u_chk (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
   .PREADY(PREADY), .PSLVERR(PSLVERR), .PRDATA(PRDATA), .CELL_Q(CELL_Q),
   .SECTOR_CLK(SECTOR_CLK), .SECTOR_SR(SECTOR_SR), .CONFIG_DONE(CONFIG_DONE));
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench for the clock and set/reset distribution block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import acrd_pkg::*;
   logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic pready, pslverr, cfg_done;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, mask = 32'h00000000, lfsr = 32'h00000ed7;
   logic [31:0] prdata, cell_d, cell_q;
   logic [7:0] gcb = 8'h00, p4 = 8'h00, p5 = 8'hff, uio = 8'h00, sclk, ssr;
   logic [3:0] fck = 4'h0, corner = 4'h0;
   logic [7:0] inj = 8'h00;
   logic [3:0] sel [4];
   logic [4:0] sc [8];
   logic [2:0] gi;
   int error_cnt = 0, checked = 0;
   always #2 clk = ~clk;
   acrd_top dut (.CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .GLOBAL_CLOCK_BUS(gcb), .FAST_CLOCK_LEFT_A(fck[0]), .FAST_CLOCK_LEFT_B(fck[1]),
      .FAST_CLOCK_RIGHT_A(fck[2]), .FAST_CLOCK_RIGHT_B(fck[3]), .CORNER_DERIVED_CLOCK(corner),
      .PLANE4_EXPRESS(p4), .PLANE5_EXPRESS(p5), .USER_IO(uio), .CELL_D(cell_d), .CELL_Q(cell_q),
      .SECTOR_CLK(sclk), .SECTOR_SR(ssr), .CONFIG_DONE(cfg_done));
   acrd_cell_user u_user (.cell_q(cell_q), .flip_mask(mask), .cell_d(cell_d));
   // ********
   // expectations
   // ********
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction : rnd
   function automatic logic [7:0] eff_bus();
      logic [7:0] b;
      b = gcb;
      for (int i = 0; i < 8; i++) begin
         if (inj[i]) b[i] = corner[i % 4];
      end
      return b;
   endfunction : eff_bus
   function automatic logic col_clk(input int c, input logic [3:0] sl);
      logic [7:0] b;
      b = eff_bus();
      if (sl < 4'h8) return b[sl[2:0]];
      if (c == 0) return fck[sl[0]];
      if (c == 3) return fck[2 + sl[0]];
      return 1'b0;
   endfunction : col_clk
   function automatic logic sec_clk(input int s);
      logic b;
      b = sc[s][0] ? p4[s] : col_clk(s / 2, sel[s / 2]);
      case (sc[s][2:1])
         ACRD_CLK_PASS: return b;
         ACRD_CLK_INV: return ~b;
         default: return 1'b0;
      endcase
   endfunction : sec_clk
   // ********
   // bus and reporting
   // ********
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         chk("pready", 32'h1, 32'h0);
         give_verdict();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic err;
      apb(1'b1, a, d, rd, err);
   endtask : wr
   // ********
   // main sequence
   // ********
   initial begin
      logic [31:0] rd, v, init, sets;
      logic [7:0] es, esr;
      logic [3:0] ec;
      logic err;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      apb(1'b0, ACRD_OFS_CELL_Q, 32'h0, rd, err);
      chk("cell_q reg", 32'hffffffff, rd);
      apb(1'b0, ACRD_OFS_SEC_LVL, 32'h0, rd, err);
      chk("levels", 32'h00ff0000, rd);
      apb(1'b0, 12'h300, 32'h0, rd, err);
      chk("unmapped", 32'h1, {rd[30:0], err});
      init = rnd();
      sets = rnd();
      for (int k = 0; k < 32; k++) begin
         wr(ACRD_OFS_CELL_BASE + 12'(4 * k), {28'h0, init[k], 2'b00, sets[k]});
      end
      // clocks tied low so only set/reset can move the cells
      for (int s = 0; s < 8; s++) begin
         wr(ACRD_OFS_SEC_BASE + 12'(4 * s), 32'h00000006);
      end
      wr(ACRD_OFS_CTRL, 32'h00000001);
      chk("init", init, cell_q);
      chk("done", 32'h1, {31'h0, cfg_done});
      p5 <= 8'h00;
      repeat (6) @(posedge clk);
      chk("sr on", sets, cell_q);
      p5 <= 8'hff;
      for (int s = 0; s < 8; s++) begin
         wr(ACRD_OFS_SEC_BASE + 12'(4 * s), 32'h0);
      end
      chk("sr off", sets, cell_q);
      v = sets;
      for (int i = 0; i < 3; i++) begin
         rd = rnd();
         mask <= rd;
         repeat (4) @(posedge clk);
         gcb <= 8'h01;
         repeat (6) @(posedge clk);
         v = v ^ rd;
         chk("rise capture", v, cell_q);
         gcb <= 8'h00;
         repeat (6) @(posedge clk);
         chk("fall ignored", v, cell_q);
      end
      // falling-edge cells, then active-high set/reset
      for (int k = 0; k < 32; k++) begin
         wr(ACRD_OFS_CELL_BASE + 12'(4 * k), {28'h0, init[k], 2'b10, sets[k]});
      end
      rd = rnd();
      mask <= rd;
      repeat (4) @(posedge clk);
      gcb <= 8'h01;
      repeat (6) @(posedge clk);
      chk("rise ignored", v, cell_q);
      gcb <= 8'h00;
      repeat (6) @(posedge clk);
      v = v ^ rd;
      chk("fall capture", v, cell_q);
      for (int k = 0; k < 32; k++) begin
         wr(ACRD_OFS_CELL_BASE + 12'(4 * k), {28'h0, init[k], 2'b01, sets[k]});
      end
      @(posedge clk);
      chk("sr high", sets, cell_q);
      p5 <= 8'h00;
      rd = rnd();
      mask <= rd;
      repeat (4) @(posedge clk);
      gcb <= 8'h01;
      repeat (6) @(posedge clk);
      chk("high idle", sets ^ rd, cell_q);
      gcb <= 8'h00;
      for (int i = 0; i < 12; i++) begin
         v = rnd();
         gi = v[2:0];
         inj = v[15:8];
         wr(ACRD_OFS_CTRL, {13'h0, gi, inj, 8'h01});
         for (int c = 0; c < 4; c++) begin
            v = rnd();
            sel[c] = (v[3:0] > 4'h9) ? v[3:0] - 4'h6 : v[3:0];
            wr(ACRD_OFS_COL_BASE + 12'(4 * c), {28'h0, sel[c]});
         end
         for (int s = 0; s < 8; s++) begin
            v = rnd();
            sc[s] = v[4:0];
            wr(ACRD_OFS_SEC_BASE + 12'(4 * s), {27'h0, sc[s]});
         end
         v = rnd();
         {uio, p4, corner, fck, gcb} <= v;
         rd = rnd();
         p5 <= rd[7:0];
         repeat (5) @(posedge clk);
         for (int s = 0; s < 8; s++) begin
            es[s] = sec_clk(s);
            esr[s] = (sc[s][3] ? uio[gi] : p5[s]) ^ sc[s][4];
         end
         for (int c = 0; c < 4; c++) begin
            ec[c] = col_clk(c, sel[c]);
         end
         apb(1'b0, ACRD_OFS_STATUS, 32'h0, rd, err);
         v = {15'h0, uio[gi], 4'h0, ec, eff_bus()};
         chk("status", v, rd);
         chk("sector clk", {24'h0, es}, {24'h0, sclk});
         chk("sector sr", {24'h0, esr}, {24'h0, ssr});
      end
      wr(ACRD_OFS_CTRL, 32'h0);
      @(posedge clk);
      chk("cells again", 32'hffffffff, cell_q);
      chk("clocks again", 32'h0, {24'h0, sclk});
      chk("done off", 32'h0, {31'h0, cfg_done});
      give_verdict();
   end
endmodule : testbench
`default_nettype wire
